// >>> bench/legacy_cmd_interp_asserts.sv
// checker for the legacy command interpreter, bound to its top module
// assumes zero wait state bus and writes decoded at offset 0x00
`timescale 1ns/100ps
`include "legacy_cmd_params.svh"
`default_nettype none
module legacy_cmd_interp_chk (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // bus
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // supply side
  input wire logic output_on_o,
  input wire logic off_indicator_o,
  input wire logic ocp_en_o,
  input wire logic [`VAL_W-1:0] volt_set_o,
  input wire logic [`VAL_W-1:0] curr_set_o
);
  logic aph;
  logic wr_ph_q;
  logic rd_odd_q;
  logic [7:0] op;
  logic [15:0] arg;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // address phase seen on the bus
  assign aph = hsel_i && htrans_i[1] && hready_i;
  assign op = hwdata_i[7:0];
  assign arg = hwdata_i[31:16];
  // data phase markers, so commands are judged on the edge they execute
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ph_q <= 1'h0;
      rd_odd_q <= 1'h0;
    end else begin
      wr_ph_q <= aph && hwrite_i && haddr_i[7:0] == `OFS_CMD;
      rd_odd_q <= aph && !hwrite_i && haddr_i[7:0] > `OFS_STATE;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  chk_off_follows: assert property (
    off_indicator_o == !output_on_o) else $error("off indication wrong");
  chk_bus_okay: assert property (
    hreadyout_o && !hresp_o) else $error("bus not ready or error");
  chk_out_on: assert property (
    wr_ph_q && op == legacy_cmd_pkg::CMD_OUTPUT && arg == `ARG_ON
    |=> output_on_o) else $error("output not switched on");
  chk_out_off: assert property (
    wr_ph_q && op == legacy_cmd_pkg::CMD_OUTPUT && arg == `ARG_OFF
    |=> !output_on_o) else $error("output not switched off");
  chk_cutoff_cv: assert property (
    wr_ph_q && op == legacy_cmd_pkg::CMD_CUTOFF && arg == `CUTOFF_CV
    |=> $stable(ocp_en_o)) else $error("cutoff code 1 changed protection");
  chk_delay_keeps: assert property (
    wr_ph_q && op inside {legacy_cmd_pkg::CMD_DELAY_SET,
    legacy_cmd_pkg::CMD_DELAY_Q} |=> $stable({volt_set_o, curr_set_o,
    ocp_en_o, output_on_o})) else $error("delay command changed setting");
  chk_quiet_stable: assert property (
    !wr_ph_q |=> $stable({volt_set_o, curr_set_o, ocp_en_o, output_on_o}))
    else $error("setting changed without command");
  chk_default_back: assert property (
    wr_ph_q && op == legacy_cmd_pkg::CMD_RETURN_DEFAULT |=>
    volt_set_o == `RST_VOLTAGE_SETPOINT_CMD && curr_set_o == `RST_CURRENT_SETPOINT_CMD && !ocp_en_o &&
    !output_on_o) else $error("return to default incomplete");
  chk_unmapped_zero: assert property (
    rd_odd_q |-> hrdata_o == 32'h0) else $error("unmapped read not zero");
  cov_cutoff: cover property (wr_ph_q && op == legacy_cmd_pkg::CMD_CUTOFF);
  cov_apply: cover property (wr_ph_q && op == legacy_cmd_pkg::CMD_APPLY);
  cov_unmapped: cover property (rd_odd_q);
endmodule // legacy_cmd_interp_chk
bind legacy_cmd_interp legacy_cmd_interp_chk chk_u (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .output_on_o(output_on_o), .off_indicator_o(off_indicator_o),
  .ocp_en_o(ocp_en_o), .volt_set_o(volt_set_o), .curr_set_o(curr_set_o));
`default_nettype wire

// >>> bench/legacy_command_interpreter_test.sv
// self-checking bench of the legacy command interpreter over AHB-Lite
// assumes the design package and constants header are compiled first
`timescale 1ns/100ps
`include "legacy_cmd_params.svh"
`default_nettype none
module legacy_command_interpreter_test;
  localparam logic [15:0] MID = 16'h0A5A; // arbitrary value
  logic clk_sys_i, rst_n_i, hsel, hwrite, hready, hresp;
  logic out_on, off_ind, overcurrent_protection;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0] status, stat_req;
  logic [15:0] meas, curr_req, voltage_setpoint_cmd, current_setpoint_cmd;
  int errors, n_compared;
  legacy_cmd_interp #(.MODEL_ID(MID)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .status_i(status), .meas_curr_i(meas), .output_on_o(out_on),
    .off_indicator_o(off_ind), .ocp_en_o(overcurrent_protection), .volt_set_o(voltage_setpoint_cmd),
    .curr_set_o(current_setpoint_cmd));
  supply_front_model front_u (.clk_sys_i(clk_sys_i),
    .stat_req_i(stat_req), .curr_req_i(curr_req), .status_o(status),
    .meas_curr_o(meas));
  // 100 MHz clock
  initial begin
    clk_sys_i = 1'h0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [35:0] e,
                     input logic [35:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one single transfer; waits on hready in both phases
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk_sys_i);
    while (hready !== 1'h1) @(posedge clk_sys_i);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= wd;
    @(posedge clk_sys_i);
    while (hready !== 1'h1) @(posedge clk_sys_i);
    rd = hrdata;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [15:0] arg);
    logic [31:0] rd;
    xfer(1'h1, `OFS_CMD, {arg, 8'h00, op}, rd);
  endtask
  // answer must be valid and tagged with the query code
  task automatic resp(input logic [7:0] op, input logic [15:0] e);
    logic [31:0] rd;
    xfer(1'h0, `OFS_RESP, 32'h0, rd);
    chk("resp", {11'h0, 1'h1, op, e}, {11'h0, rd[31], rd[23:0]});
  endtask
  task automatic qry(input logic [7:0] op, input logic [15:0] e);
    cmd(op, 16'h0000);
    resp(op, e);
  endtask
  // applied settings, one edge after the command executed
  task automatic outs(input logic o, input logic c, input logic [15:0] v,
                      input logic [15:0] i);
    @(posedge clk_sys_i);
    chk("outputs", {1'h0, o, !o, c, v, i},
        {1'h0, out_on, off_ind, overcurrent_protection, voltage_setpoint_cmd, current_setpoint_cmd});
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #50000;
    errors++;
    conclude;
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    {rst_n_i, hsel, htrans, hwrite, haddr, hwdata} = '0;
    hsize = 3'h2;
    stat_req = 8'h00;
    curr_req = 16'h0000;
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    repeat (4) @(posedge clk_sys_i);
    qry(legacy_cmd_pkg::CMD_CURR_Q, `RST_CURRENT_SETPOINT_CMD);
    qry(legacy_cmd_pkg::CMD_SOFT_LIMIT_Q, `RST_CURRENT_SOFT_LIMIT);
    qry(legacy_cmd_pkg::CMD_CUTOFF_Q, `CUTOFF_CC);
    qry(legacy_cmd_pkg::CMD_DEFER_Q, `DEFER_REPORT);
    qry(legacy_cmd_pkg::CMD_MODEL_Q, MID);
    qry(legacy_cmd_pkg::CMD_OUTPUT_Q, `ARG_OFF);
    qry(legacy_cmd_pkg::CMD_ERROR_Q, {8'h0, `ERR_NONE});
    cmd(legacy_cmd_pkg::CMD_OUTPUT, `ARG_ON);
    outs(1'h1, 1'h0, 16'h0, 16'h0);
    qry(legacy_cmd_pkg::CMD_OUTPUT_Q, `ARG_ON);
    cmd(legacy_cmd_pkg::CMD_OUTPUT, `ARG_OFF);
    outs(1'h0, 1'h0, 16'h0, 16'h0);
    // limit boundary: equal is taken, one above is refused
    cmd(legacy_cmd_pkg::CMD_SOFT_LIMIT, 16'h0100);
    cmd(legacy_cmd_pkg::CMD_CURR_SET, 16'h0100);
    cmd(legacy_cmd_pkg::CMD_CURR_SET, 16'h0101);
    outs(1'h0, 1'h0, 16'h0, 16'h0100);
    qry(legacy_cmd_pkg::CMD_ERROR_Q, {8'h0, `ERR_LIMIT});
    qry(legacy_cmd_pkg::CMD_ERROR_Q, {8'h0, `ERR_NONE});
    qry(legacy_cmd_pkg::CMD_CURR_Q, 16'h0100);
    cmd(legacy_cmd_pkg::CMD_CUTOFF, `CUTOFF_CC);
    outs(1'h0, 1'h1, 16'h0, 16'h0100);
    cmd(legacy_cmd_pkg::CMD_CUTOFF, `CUTOFF_CV);
    outs(1'h0, 1'h1, 16'h0, 16'h0100);
    qry(legacy_cmd_pkg::CMD_ERROR_Q, {8'h0, `ERR_NOT_SUPPORTED});
    cmd(legacy_cmd_pkg::CMD_DELAY_SET, 16'h0005);
    qry(legacy_cmd_pkg::CMD_ERROR_Q, {8'h0, `ERR_NOT_SUPPORTED});
    cmd(legacy_cmd_pkg::CMD_DELAY_Q, 16'h0000);
    qry(legacy_cmd_pkg::CMD_ERROR_Q, {8'h0, `ERR_NOT_SUPPORTED});
    // a code outside the set and a bad argument both leave a code behind
    cmd(8'h7F, 16'h0000);
    qry(legacy_cmd_pkg::CMD_ERROR_Q, {8'h0, `ERR_UNKNOWN});
    cmd(legacy_cmd_pkg::CMD_OUTPUT, 16'h0002);
    outs(1'h0, 1'h1, 16'h0, 16'h0100);
    qry(legacy_cmd_pkg::CMD_ERROR_Q, {8'h0, `ERR_BAD_ARG});
    // held values wait for the apply command
    cmd(legacy_cmd_pkg::CMD_DEFER, `ARG_ON);
    cmd(legacy_cmd_pkg::CMD_VOLT_SET, 16'h1234);
    cmd(legacy_cmd_pkg::CMD_CURR_SET, 16'h0050);
    cmd(legacy_cmd_pkg::CMD_CUTOFF, `ARG_OFF);
    cmd(legacy_cmd_pkg::CMD_MASK_SET, 16'h00F0);
    outs(1'h0, 1'h1, 16'h0, 16'h0100);
    qry(legacy_cmd_pkg::CMD_MASK_Q, 16'h0000);
    // all four held flags, protection on, deferring, no answer pending
    xfer(1'h0, `OFS_STATE, 32'h0, rd);
    chk("state", 36'hFC, {4'h0, rd});
    cmd(legacy_cmd_pkg::CMD_APPLY, 16'h0000);
    outs(1'h0, 1'h0, 16'h1234, 16'h0050);
    qry(legacy_cmd_pkg::CMD_VOLT_Q, 16'h1234);
    qry(legacy_cmd_pkg::CMD_MASK_Q, 16'h00F0);
    cmd(legacy_cmd_pkg::CMD_DEFER, `ARG_OFF);
    // status burst, then quiet before the reads
    cmd(legacy_cmd_pkg::CMD_MASK_SET, 16'h0005);
    stat_req <= 8'h07;
    repeat (4) @(posedge clk_sys_i);
    stat_req <= 8'h00;
    repeat (6) @(posedge clk_sys_i);
    qry(legacy_cmd_pkg::CMD_FAULT_Q, 16'h0005);
    qry(legacy_cmd_pkg::CMD_FAULT_Q, 16'h0000);
    qry(legacy_cmd_pkg::CMD_ACC_STATUS_Q, 16'h0007);
    qry(legacy_cmd_pkg::CMD_ACC_STATUS_Q, 16'h0000);
    // second query before the first answer is read
    curr_req <= 16'h0321;
    cmd(legacy_cmd_pkg::CMD_MODEL_Q, 16'h0000);
    cmd(legacy_cmd_pkg::CMD_MEAS_CURR_Q, 16'h0000);
    resp(legacy_cmd_pkg::CMD_MODEL_Q, MID);
    qry(legacy_cmd_pkg::CMD_ERROR_Q, {8'h0, `ERR_UNREAD});
    qry(legacy_cmd_pkg::CMD_MEAS_CURR_Q, 16'h0321);
    cmd(legacy_cmd_pkg::CMD_OUTPUT, `ARG_ON);
    cmd(legacy_cmd_pkg::CMD_RETURN_DEFAULT, 16'h0000);
    outs(1'h0, 1'h0, `RST_VOLTAGE_SETPOINT_CMD, `RST_CURRENT_SETPOINT_CMD);
    qry(legacy_cmd_pkg::CMD_SOFT_LIMIT_Q, `RST_CURRENT_SOFT_LIMIT);
    xfer(1'h0, 8'h0C, 32'h0, rd);
    chk("unmapped", 36'h0, {4'h0, rd});
    conclude;
  end
endmodule // legacy_command_interpreter_test
`default_nettype wire

// >>> bench/supply_front_model.sv
// model of the supply front end: status bits and measured current
// assumes the bench sets the wanted levels; the model lags one cycle
`timescale 1ns/100ps
`default_nettype none
module supply_front_model (
  // clock
  input wire logic clk_sys_i,
  // wanted levels
  input wire logic [7:0] stat_req_i,
  input wire logic [15:0] curr_req_i,
  // front end outputs
  output logic [7:0] status_o,
  output logic [15:0] meas_curr_o
);
  // registered, as a real converter never answers in the same cycle
  always_ff @(posedge clk_sys_i) begin
    status_o <= stat_req_i;
    meas_curr_o <= curr_req_i;
  end
endmodule // supply_front_model
`default_nettype wire

// >>> core/legacy_cmd_interp.sv
// top of the legacy command interpreter: AHB-Lite slave, dispatcher,
// settings, status, fault and error registers
// assumes one 100 MHz clock, a single AHB-Lite master, and a supply
// front end that takes the setpoints and returns status and current
`timescale 1ns/100ps
`include "legacy_cmd_params.svh"
`default_nettype none

// Overview of operation
// - every legacy command code is decoded; the two delay codes only raise error 203
// - accumulated status query returns bitwise OR of status, then reloads present status
// - return-default command restores all settings to power-on values
// - error query returns present error code and clears the error register
// - fault bit sets when status bit and mask bit are both set
// - fault query returns eight-bit value, then reloads present masked status
// - cutoff code 2 sets protection; code 1 raises error 203
// - cutoff query always answers constant-current code 2
// - while deferring, voltage, current, cutoff and mask wait for apply
// - defer query always answers 1
// - model query returns the model identification value
// - current above the soft limit raises an error, value not applied
// - measured current, current setpoint and soft limit are queryable
// - current command loads setpoint, subject to limit and deferral
// - output command: 1 switches output on, 0 switches it off
// - output query answers 1 or 0; off indicator follows output off
// - a query while the previous answer is unread raises an error
// - apply command loads every value held by deferral
module legacy_cmd_interp #(
  parameter logic [`VAL_W-1:0] MODEL_ID = 16'h0A5A // arbitrary value
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // supply front end
  input wire logic [`STAT_W-1:0] status_i,
  input wire logic [`VAL_W-1:0] meas_curr_i,
  output logic output_on_o,
  output logic off_indicator_o,
  output logic ocp_en_o,
  output logic [`VAL_W-1:0] volt_set_o,
  output logic [`VAL_W-1:0] curr_set_o
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic rst_n;

  // assert at once, release after two edges so all flops leave together
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // command codes that produce an answer in the response register
  function automatic logic is_query(input logic [7:0] op);
    case (op)
      legacy_cmd_pkg::CMD_ACC_STATUS_Q,
      legacy_cmd_pkg::CMD_ERROR_Q,
      legacy_cmd_pkg::CMD_FAULT_Q,
      legacy_cmd_pkg::CMD_CUTOFF_Q,
      legacy_cmd_pkg::CMD_DEFER_Q,
      legacy_cmd_pkg::CMD_MODEL_Q,
      legacy_cmd_pkg::CMD_SOFT_LIMIT_Q,
      legacy_cmd_pkg::CMD_MEAS_CURR_Q,
      legacy_cmd_pkg::CMD_CURR_Q,
      legacy_cmd_pkg::CMD_OUTPUT_Q,
      legacy_cmd_pkg::CMD_VOLT_Q,
      legacy_cmd_pkg::CMD_MASK_Q: is_query = 1'b1;
      default: is_query = 1'b0;
    endcase
  endfunction

  // settings at power-on, shared by reset and the return-default command
  function automatic legacy_cmd_pkg::state_t set_default(
    input legacy_cmd_pkg::state_t s
  );
    legacy_cmd_pkg::state_t r;
    r = s;
    r.out_on = 1'b0;
    r.hold = 1'b0;
    r.ocp_en = 1'b0;
    r.mask = `RST_MASK;
    r.voltage_setpoint_cmd = `RST_VOLTAGE_SETPOINT_CMD;
    r.current_setpoint_cmd = `RST_CURRENT_SETPOINT_CMD;
    r.current_soft_limit = `RST_CURRENT_SOFT_LIMIT;
    r.p_voltage_setpoint_cmd = `RST_VOLTAGE_SETPOINT_CMD;
    r.p_current_setpoint_cmd = `RST_CURRENT_SETPOINT_CMD;
    r.p_ocp = 1'b0;
    r.p_mask = `RST_MASK;
    r.p_flags = 4'h0;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  legacy_cmd_pkg::state_t q, n;
  logic take;
  logic q_go;
  logic [`VAL_W-1:0] q_val;
  logic [7:0] op;
  logic [`VAL_W-1:0] arg;
  logic [`ADDR_LSB_W-1:0] aofs;

  // next-state logic: bus, synchronisers, status and command dispatch
  always_comb begin
    n = q;
    q_go = 1'b0;
    q_val = '0;
    op = hwdata_i[`CMD_OP_LSB +: 8];
    arg = hwdata_i[`CMD_ARG_LSB +: `VAL_W];
    aofs = haddr_i[`ADDR_LSB_W-1:0];
    take = hsel_i & htrans_i[1] & hready_i;

    // pins from the analog side pass two flops first; the current word
    // may tear on a change, so a query can see one mixed sample
    n.stat_s1 = status_i;
    n.stat_s2 = q.stat_s1;
    n.meas_s1 = meas_curr_i;
    n.meas_s2 = q.meas_s1;

    // sticky accumulation; new events are added before any clear below
    n.acc = q.acc | q.stat_s2;
    n.fault = q.fault | (q.stat_s2 & q.mask);

    // address phase: note a command write, prepare read data
    n.wr_pend = take & hwrite_i & (aofs == `OFS_CMD);
    if (take && !hwrite_i) begin
      case (aofs)
        `OFS_RESP: begin
          n.hrdata = {q.resp_valid, 7'h00, q.resp_tag, q.resp};
          n.resp_valid = 1'b0; // reading the answer frees the slot
        end
        `OFS_STATE: begin
          n.hrdata = {q.err, 16'h0000, q.p_flags, q.ocp_en, q.hold,
                      q.resp_valid, q.out_on};
        end
        default: n.hrdata = 32'h0000_0000; // command and unmapped
      endcase
    end

    // data phase of a command write: decode and dispatch
    if (q.wr_pend) begin
      if (is_query(op) && q.resp_valid) begin
        n.err = `ERR_UNREAD;
      end else begin
        case (op)
          legacy_cmd_pkg::CMD_ACC_STATUS_Q: begin
            q_go = 1'b1;
            q_val = {8'h00, q.acc};
            n.acc = q.stat_s2;
          end
          legacy_cmd_pkg::CMD_RETURN_DEFAULT: begin
            n = set_default(n);
          end
          legacy_cmd_pkg::CMD_DELAY_SET,
          legacy_cmd_pkg::CMD_DELAY_Q: begin
            n.err = `ERR_NOT_SUPPORTED;
          end
          legacy_cmd_pkg::CMD_ERROR_Q: begin
            q_go = 1'b1;
            q_val = {8'h00, q.err};
            n.err = `ERR_NONE;
          end
          legacy_cmd_pkg::CMD_FAULT_Q: begin
            q_go = 1'b1;
            q_val = {8'h00, q.fault};
            n.fault = q.stat_s2 & q.mask;
          end
          legacy_cmd_pkg::CMD_CUTOFF: begin
            if (arg == `CUTOFF_CV) begin
              n.err = `ERR_NOT_SUPPORTED;
            end else if (arg != `CUTOFF_CC && arg != `ARG_OFF) begin
              n.err = `ERR_BAD_ARG;
            end else if (q.hold) begin
              n.p_ocp = (arg == `CUTOFF_CC);
              n.p_flags[2] = 1'b1;
            end else begin
              n.ocp_en = (arg == `CUTOFF_CC);
            end
          end
          legacy_cmd_pkg::CMD_CUTOFF_Q: begin
            q_go = 1'b1;
            q_val = `CUTOFF_CC;
          end
          legacy_cmd_pkg::CMD_DEFER: begin
            if (arg == `ARG_ON || arg == `ARG_OFF) begin
              n.hold = arg[0];
            end else begin
              n.err = `ERR_BAD_ARG;
            end
          end
          legacy_cmd_pkg::CMD_DEFER_Q: begin
            q_go = 1'b1;
            q_val = `DEFER_REPORT;
          end
          legacy_cmd_pkg::CMD_MODEL_Q: begin
            q_go = 1'b1;
            q_val = MODEL_ID;
          end
          legacy_cmd_pkg::CMD_SOFT_LIMIT: begin
            n.current_soft_limit = arg;
          end
          legacy_cmd_pkg::CMD_SOFT_LIMIT_Q: begin
            q_go = 1'b1;
            q_val = q.current_soft_limit;
          end
          legacy_cmd_pkg::CMD_MEAS_CURR_Q: begin
            q_go = 1'b1;
            q_val = q.meas_s2;
          end
          legacy_cmd_pkg::CMD_CURR_SET: begin
            // limit checked now only, so a held value is not checked again at apply
            if (arg > q.current_soft_limit) begin
              n.err = `ERR_LIMIT;
            end else if (q.hold) begin
              n.p_current_setpoint_cmd = arg;
              n.p_flags[1] = 1'b1;
            end else begin
              n.current_setpoint_cmd = arg;
            end
          end
          legacy_cmd_pkg::CMD_CURR_Q: begin
            q_go = 1'b1;
            q_val = q.current_setpoint_cmd;
          end
          legacy_cmd_pkg::CMD_OUTPUT: begin
            if (arg == `ARG_ON || arg == `ARG_OFF) begin
              n.out_on = arg[0];
            end else begin
              n.err = `ERR_BAD_ARG;
            end
          end
          legacy_cmd_pkg::CMD_OUTPUT_Q: begin
            q_go = 1'b1;
            q_val = {15'h0000, q.out_on};
          end
          legacy_cmd_pkg::CMD_VOLT_SET: begin
            if (q.hold) begin
              n.p_voltage_setpoint_cmd = arg;
              n.p_flags[0] = 1'b1;
            end else begin
              n.voltage_setpoint_cmd = arg;
            end
          end
          legacy_cmd_pkg::CMD_VOLT_Q: begin
            q_go = 1'b1;
            q_val = q.voltage_setpoint_cmd;
          end
          legacy_cmd_pkg::CMD_MASK_SET: begin
            if (q.hold) begin
              n.p_mask = arg[`STAT_W-1:0];
              n.p_flags[3] = 1'b1;
            end else begin
              n.mask = arg[`STAT_W-1:0];
            end
          end
          legacy_cmd_pkg::CMD_MASK_Q: begin
            q_go = 1'b1;
            q_val = {8'h00, q.mask};
          end
          legacy_cmd_pkg::CMD_APPLY: begin
            if (q.p_flags[0]) n.voltage_setpoint_cmd = q.p_voltage_setpoint_cmd;
            if (q.p_flags[1]) n.current_setpoint_cmd = q.p_current_setpoint_cmd;
            if (q.p_flags[2]) n.ocp_en = q.p_ocp;
            if (q.p_flags[3]) n.mask = q.p_mask;
            n.p_flags = 4'h0;
          end
          // codes outside the legacy set are rejected with the unknown-code error
          default: n.err = `ERR_UNKNOWN;
        endcase
      end
    end

    // one answer slot; a new answer wins over a read in the same cycle
    if (q_go) begin
      n.resp = q_val;
      n.resp_tag = op;
      n.resp_valid = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= set_default('0);
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // zero wait states and only OKAY answers; hsize is not checked since
  // the master only issues whole words
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = q.hrdata;
  assign output_on_o = q.out_on;
  assign off_indicator_o = ~q.out_on;
  assign ocp_en_o = q.ocp_en;
  assign volt_set_o = q.voltage_setpoint_cmd;
  assign curr_set_o = q.current_setpoint_cmd;

endmodule // legacy_cmd_interp

`default_nettype wire

// >>> core/legacy_cmd_params.svh
// constants of the legacy command interpreter: offsets, codes, resets
// assumes inclusion by bare name from the package and the top module
`ifndef LEGACY_CMD_PARAMS_SVH
`define LEGACY_CMD_PARAMS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define VAL_W 16
`define STAT_W 8
`define ADDR_LSB_W 8

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CMD 8'h00
`define OFS_RESP 8'h04
`define OFS_STATE 8'h08

// ----------------------------------------------------------------
// command word fields
// ----------------------------------------------------------------
`define CMD_OP_LSB 0
`define CMD_ARG_LSB 16

// ----------------------------------------------------------------
// error codes
// ----------------------------------------------------------------
`define ERR_NONE 8'h00
`define ERR_UNKNOWN 8'h01
`define ERR_LIMIT 8'h04
`define ERR_UNREAD 8'h08
`define ERR_BAD_ARG 8'h10
`define ERR_NOT_SUPPORTED 8'hCB

// ----------------------------------------------------------------
// argument codes and fixed answers
// ----------------------------------------------------------------
`define ARG_OFF 16'h0000
`define ARG_ON 16'h0001
`define CUTOFF_CV 16'h0001
`define CUTOFF_CC 16'h0002
`define DEFER_REPORT 16'h0001

// ----------------------------------------------------------------
// power-on values
// ----------------------------------------------------------------
`define RST_VOLTAGE_SETPOINT_CMD 16'h0000
`define RST_CURRENT_SETPOINT_CMD 16'h0000
`define RST_CURRENT_SOFT_LIMIT 16'hFFFF
`define RST_MASK 8'h00

`endif

// >>> core/legacy_cmd_pkg.sv
// types of the legacy command interpreter: command codes and state
// assumes the constants header is on the include path
`include "legacy_cmd_params.svh"

package legacy_cmd_pkg;

  // ----------------------------------------------------------------
  // command codes, low byte of the command word
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    CMD_ACC_STATUS_Q = 8'h01,
    CMD_RETURN_DEFAULT = 8'h02,
    CMD_DELAY_SET = 8'h03,
    CMD_DELAY_Q = 8'h04,
    CMD_ERROR_Q = 8'h05,
    CMD_FAULT_Q = 8'h06,
    CMD_CUTOFF = 8'h07,
    CMD_CUTOFF_Q = 8'h08,
    CMD_DEFER = 8'h09,
    CMD_DEFER_Q = 8'h0A,
    CMD_MODEL_Q = 8'h0B,
    CMD_SOFT_LIMIT = 8'h0C,
    CMD_SOFT_LIMIT_Q = 8'h0D,
    CMD_MEAS_CURR_Q = 8'h0E,
    CMD_CURR_SET = 8'h0F,
    CMD_CURR_Q = 8'h10,
    CMD_OUTPUT = 8'h11,
    CMD_OUTPUT_Q = 8'h12,
    CMD_VOLT_SET = 8'h13,
    CMD_VOLT_Q = 8'h14,
    CMD_MASK_SET = 8'h15,
    CMD_MASK_Q = 8'h16,
    CMD_APPLY = 8'h17
  } cmd_op_t;

  // ----------------------------------------------------------------
  // whole state of the interpreter
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`STAT_W-1:0] stat_s1;
    logic [`STAT_W-1:0] stat_s2;
    logic [`VAL_W-1:0] meas_s1;
    logic [`VAL_W-1:0] meas_s2;
    logic out_on;
    logic hold;
    logic ocp_en;
    logic [`STAT_W-1:0] mask;
    logic [`VAL_W-1:0] voltage_setpoint_cmd;
    logic [`VAL_W-1:0] current_setpoint_cmd;
    logic [`VAL_W-1:0] current_soft_limit;
    logic [`VAL_W-1:0] p_voltage_setpoint_cmd;
    logic [`VAL_W-1:0] p_current_setpoint_cmd;
    logic p_ocp;
    logic [`STAT_W-1:0] p_mask;
    logic [3:0] p_flags;
    logic [`STAT_W-1:0] acc;
    logic [`STAT_W-1:0] fault;
    logic [7:0] err;
    logic [`VAL_W-1:0] resp;
    logic [7:0] resp_tag;
    logic resp_valid;
    logic wr_pend;
    logic [31:0] hrdata;
  } state_t;

endpackage : legacy_cmd_pkg
